// ---- rtl/tef_pkg.sv ----
package tef_pkg;

  // Register bus geometry
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int REG_W = 16;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFF_REQ_EN = 12'h00C;
  localparam logic [ADDR_W-1:0] OFF_FLAGS = 12'h010;
  localparam logic [ADDR_W-1:0] OFF_ERR_STAT = 12'h018;
  localparam logic [ADDR_W-1:0] OFF_ERR_MASK = 12'h01C;
  localparam logic [ADDR_W-1:0] OFF_TRIG_SEL = 12'h020;

  // Reset values
  localparam logic [REG_W-1:0] RST_REQ_EN = 16'h0000;
  localparam logic [REG_W-1:0] RST_FLAGS = 16'h0000;
  localparam logic [3:0] RST_ERR = 4'h0;
  localparam logic [7:0] RST_TRIG_SEL = 8'h00;

  // Writable bit masks; reserved bits read as zero
  localparam logic [REG_W-1:0] MASK_REQ_EN = 16'h7FFF;
  localparam logic [REG_W-1:0] MASK_FLAGS = 16'h1EFF;

  // Field positions; bits 0..7 shared by request_enable and event_flags, BIT_DMA in request_enable only, BIT_REP in event_flags only
  localparam int BIT_UPD = 0;
  localparam int BIT_CH = 1;
  localparam int NUM_CH = 4;
  localparam int BIT_COM = 5;
  localparam int BIT_TRG = 6;
  localparam int BIT_BRK = 7;
  localparam int NUM_IRQ = 8;
  localparam int BIT_DMA = 8;
  localparam int NUM_DMA = 7;
  localparam int BIT_REP = 9;

  // Trigger select register fields
  localparam int TSEL_FIRST_LSB = 0;
  localparam int TSEL_EIGHTH_LSB = 4;
  localparam int TSEL_W = 3;

  // Internal trigger select codes
  localparam logic [2:0] TS_INTERNAL_TRIGGER_ZERO = 3'h0;
  localparam logic [2:0] TS_INTERNAL_TRIGGER_ONE = 3'h1;
  localparam logic [2:0] TS_INTERNAL_TRIGGER_TWO = 3'h2;
  localparam logic [2:0] TS_INTERNAL_TRIGGER_THREE = 3'h3;

  // Source timer index within the trigger output vector
  localparam int SRC_T1 = 0;
  localparam int SRC_T2 = 1;
  localparam int SRC_T3 = 2;
  localparam int SRC_T4 = 3;
  localparam int SRC_T5 = 4;
  localparam int NUM_SRC = 5;

endpackage : tef_pkg

// ---- rtl/tef_reg_if.sv ----
`timescale 1ns/1ps
interface tef_reg_if;
  import tef_pkg::*;
  logic wr;
  logic [ADDR_W-1:0] addr;
  logic [REG_W-1:0] wdata;
  logic [REG_W-1:0] rdata;
  logic hit;
  modport bus (output wr, addr, wdata, input rdata, hit);
  modport regs (input wr, addr, wdata, output rdata, hit);
endinterface : tef_reg_if

// ---- rtl/tef_apb_slave.sv ----
`timescale 1ns/1ps
module tef_apb_slave
  import tef_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] pwdata,
  output logic [DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // Register side
  tef_reg_if.bus rif
);

  logic setup;
  logic access;

  assign setup = psel && !penable;
  assign access = psel && penable;

  // Zero wait states: every access completes in one access cycle
  assign pready = 1'b1;
  assign pslverr = access && !rif.hit;

  assign rif.addr = paddr;
  assign rif.wdata = pwdata[REG_W-1:0];
  assign rif.wr = access && pwrite && rif.hit;

  // Read data captured in the setup cycle so it comes from a flop
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      prdata <= '0;
    end else if (setup && !pwrite) begin
      prdata <= rif.hit ? {{(DATA_W-REG_W){1'b0}}, rif.rdata} : '0;
    end
  end

endmodule : tef_apb_slave

// ---- rtl/tef_trig_route.sv ----
`timescale 1ns/1ps
module tef_trig_route
  import tef_pkg::*;
(
  // Trigger outputs of the source timers
  input wire logic [NUM_SRC-1:0] src_trig,
  // Select codes of the two slave timers
  input wire logic [TSEL_W-1:0] sel_first,
  input wire logic [TSEL_W-1:0] sel_eighth,
  // Selected internal triggers
  output logic itr_first,
  output logic itr_eighth
);

  // Codes above 011 select no internal trigger and drive the output low
  function automatic logic pick(input logic [TSEL_W-1:0] sel,
                                input logic [NUM_SRC-1:0] src,
                                input int i0, input int i1,
                                input int i2, input int i3);
    logic r;
    r = 1'b0;
    unique case (sel)
      TS_INTERNAL_TRIGGER_ZERO: r = src[i0];
      TS_INTERNAL_TRIGGER_ONE: r = src[i1];
      TS_INTERNAL_TRIGGER_TWO: r = src[i2];
      TS_INTERNAL_TRIGGER_THREE: r = src[i3];
      default: r = 1'b0;
    endcase
    return r;
  endfunction : pick

  assign itr_first = pick(sel_first, src_trig,
                          SRC_T5, SRC_T2, SRC_T3, SRC_T4);
  assign itr_eighth = pick(sel_eighth, src_trig,
                           SRC_T1, SRC_T2, SRC_T4, SRC_T5);

endmodule : tef_trig_route

// ---- rtl/tef_timer_events.sv ----
// Contract
// - First advanced timer slave: codes 000..011 select timers 5, 2, 3, 4.
// - Enable register at 0x0C resets zero; bits 0..7 enable interrupts.
// - Enable bits 8..14 enable DMA requests; bit 15 reserved.
// - Flags at 0x10 reset zero; bit 0 set on update, software clears.
// - Repetition overrun with update enabled sets the update flag.
// - Software update generate, source select and disable at 0, sets it.
// - Trigger reinit with select and disable at 0 also sets it.
// - Output channel 1 flag set when counter equals compare value.
// - Input channel 1 flag set on capture; zero if none happened.
// - Channel 1 flag cleared by write or by reading its capture register.
// - Channels 2..4 flags at bits 2..4 behave like channel 1.
// - Trigger flag at bit 6 set on trigger event, software clears.
//
// Register access over APB was chosen for this implementation.
`timescale 1ns/1ps
module tef_timer_events
  import tef_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] pwdata,
  output logic [DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // Counter core controls and events
  input wire logic update_disable,
  input wire logic update_source_select,
  input wire logic update_generate,
  input wire logic rep_overflow,
  input wire logic trig_reinit,
  input wire logic trig_event,
  input wire logic com_event,
  input wire logic break_active,
  // Channel events
  input wire logic [NUM_CH-1:0] chan_is_input,
  input wire logic [NUM_CH-1:0] chan_match,
  input wire logic [NUM_CH-1:0] chan_capture,
  input wire logic [NUM_CH-1:0] chan_cc_read,
  // Internal trigger routing
  input wire logic [NUM_SRC-1:0] src_trig,
  output logic itr_first,
  output logic itr_eighth,
  // Update event toward the counter core
  output logic update_event,
  // Requests toward interrupt and DMA controllers
  output logic irq,
  output logic [NUM_IRQ-1:0] irq_src,
  output logic [NUM_DMA-1:0] dma_req
);

  tef_reg_if rif ();

  tef_apb_slave u_apb (
    .sys_clk (sys_clk),
    .rst_n (rst_n),
    .psel (psel),
    .penable (penable),
    .pwrite (pwrite),
    .paddr (paddr),
    .pwdata (pwdata),
    .prdata (prdata),
    .pready (pready),
    .pslverr (pslverr),
    .rif (rif)
  );

  logic [REG_W-1:0] request_enable;
  logic [REG_W-1:0] event_flags;
  logic [NUM_CH-1:0] err_status;
  logic [NUM_CH-1:0] err_mask;
  logic [7:0] trig_sel;

  logic [REG_W-1:0] next_flags;
  logic [REG_W-1:0] flag_set;
  logic [REG_W-1:0] flag_keep;
  logic [NUM_CH-1:0] next_err;
  logic upd_ev;
  logic [NUM_CH-1:0] ch_ev;
  logic [NUM_CH-1:0] rep_ev;

  function automatic logic reg_sel(input logic [ADDR_W-1:0] a,
                                   input logic [ADDR_W-1:0] off);
    return a == off;
  endfunction : reg_sel

  // Address decode and read mux
  always_comb begin
    rif.hit = 1'b1;
    rif.rdata = '0;
    if (reg_sel(rif.addr, OFF_REQ_EN)) begin
      rif.rdata = request_enable;
    end else if (reg_sel(rif.addr, OFF_FLAGS)) begin
      rif.rdata = event_flags;
    end else if (reg_sel(rif.addr, OFF_ERR_STAT)) begin
      rif.rdata = {{(REG_W-NUM_CH){1'b0}}, err_status};
    end else if (reg_sel(rif.addr, OFF_ERR_MASK)) begin
      rif.rdata = {{(REG_W-NUM_CH){1'b0}}, err_mask};
    end else if (reg_sel(rif.addr, OFF_TRIG_SEL)) begin
      rif.rdata = {{(REG_W-8){1'b0}}, trig_sel};
    end else begin
      rif.hit = 1'b0;
    end
  end

  // Request enables
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      request_enable <= RST_REQ_EN;
    end else if (rif.wr && reg_sel(rif.addr, OFF_REQ_EN)) begin
      request_enable <= rif.wdata & MASK_REQ_EN;
    end
  end

  // Trigger source selects for the two slave timers
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      trig_sel <= RST_TRIG_SEL;
    end else if (rif.wr && reg_sel(rif.addr, OFF_TRIG_SEL)) begin
      trig_sel <= rif.wdata[7:0];
    end
  end

  tef_trig_route u_route (
    .src_trig (src_trig),
    .sel_first (trig_sel[TSEL_FIRST_LSB +: TSEL_W]),
    .sel_eighth (trig_sel[TSEL_EIGHTH_LSB +: TSEL_W]),
    .itr_first (itr_first),
    .itr_eighth (itr_eighth)
  );

  // Update event: software and trigger sources are muted by the
  // source select, the repetition counter is not
  always_comb begin
    upd_ev = 1'b0;
    if (!update_disable) begin
      upd_ev = rep_overflow;
      if (!update_source_select) begin
        upd_ev = upd_ev || update_generate
                 || trig_reinit;
      end
    end
  end

  // Channel events: match in output mode, capture in input mode
  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      ch_ev[i] = chan_is_input[i] ? chan_capture[i]
                                  : chan_match[i];
      rep_ev[i] = chan_is_input[i] && chan_capture[i]
                  && event_flags[BIT_CH+i];
    end
  end

  always_comb begin
    flag_set = '0;
    flag_set[BIT_UPD] = upd_ev;
    flag_set[BIT_CH +: NUM_CH] = ch_ev;
    flag_set[BIT_COM] = com_event;
    flag_set[BIT_TRG] = trig_event;
    flag_set[BIT_BRK] = break_active;
    flag_set[BIT_REP +: NUM_CH] = rep_ev;
  end

  // Bits that survive this cycle before any new event is added
  always_comb begin
    flag_keep = event_flags;
    if (rif.wr && reg_sel(rif.addr, OFF_FLAGS)) begin
      flag_keep = flag_keep & rif.wdata;
    end
    for (int i = 0; i < NUM_CH; i++) begin
      if (chan_cc_read[i]) begin
        flag_keep[BIT_CH+i] = 1'b0;
      end
    end
    // A new event wins over a clear in the same cycle
    next_flags = (flag_keep | flag_set) & MASK_FLAGS;
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      event_flags <= RST_FLAGS;
    end else begin
      event_flags <= next_flags;
    end
  end

  // Repeat captures are also logged as sticky, write-one-to-clear errors
  always_comb begin
    next_err = err_status;
    if (rif.wr && reg_sel(rif.addr, OFF_ERR_STAT)) begin
      next_err = next_err & ~rif.wdata[NUM_CH-1:0];
    end
    next_err = next_err | rep_ev;
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      err_status <= RST_ERR;
    end else begin
      err_status <= next_err;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      err_mask <= RST_ERR;
    end else if (rif.wr && reg_sel(rif.addr, OFF_ERR_MASK)) begin
      err_mask <= rif.wdata[NUM_CH-1:0];
    end
  end

  // Requests
  assign irq_src = event_flags[NUM_IRQ-1:0]
                   & request_enable[NUM_IRQ-1:0];
  assign irq = (|irq_src) || (|(err_status & err_mask));

  // DMA request pulses for one cycle per event, in the same cycle the flag rises
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      dma_req <= '0;
    end else begin
      dma_req <= flag_set[NUM_DMA-1:0]
                 & request_enable[BIT_DMA +: NUM_DMA];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      update_event <= 1'b0;
    end else begin
      update_event <= upd_ev;
    end
  end

endmodule : tef_timer_events

// ---- sim/tef_req_sink.sv ----
`timescale 1ns/1ps
module tef_req_sink
  import tef_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Requests from the timer
  input wire logic [NUM_DMA-1:0] dma_req,
  // Served request count
  output logic [7:0] n_dma
);
  // Each pulse is one served transfer; a stuck level would overcount
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      n_dma <= 8'h00;
    end else begin
      n_dma <= n_dma + 8'($countones(dma_req));
    end
  end
endmodule : tef_req_sink

// ---- sim/tef_timer_events_sva.sv ----
`timescale 1ns/1ps
module tef_timer_events_sva
  import tef_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Bus
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic pslverr,
  // Events
  input wire logic update_disable,
  input wire logic update_source_select,
  input wire logic update_generate,
  input wire logic rep_overflow,
  input wire logic trig_reinit,
  input wire logic trig_event,
  input wire logic [NUM_CH-1:0] chan_cc_read,
  // Requests
  input wire logic update_event,
  input wire logic irq,
  input wire logic [NUM_IRQ-1:0] irq_src,
  input wire logic [NUM_DMA-1:0] dma_req
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  logic wr_acc;
  logic bad;
  logic gate;
  assign wr_acc = psel & penable & pwrite;
  assign bad = !(paddr inside {OFF_REQ_EN, OFF_FLAGS, OFF_ERR_STAT,
    OFF_ERR_MASK, OFF_TRIG_SEL});
  assign gate = !update_disable && !update_source_select;
  sequence s_bad_acc;
    (psel && !penable && bad) ##1 (psel && penable && bad);
  endsequence
  property p_gen;
    update_generate && gate |=> update_event;
  endproperty
  property p_rep;
    rep_overflow && !update_disable |=> update_event;
  endproperty
  property p_reinit;
    trig_reinit && gate |=> update_event;
  endproperty
  property p_irq;
    |irq_src |-> irq;
  endproperty
  property p_slverr;
    s_bad_acc |-> pslverr;
  endproperty
  property p_dma_trg;
    dma_req[BIT_TRG] |-> $past(trig_event);
  endproperty
  property p_upd_set;
    $rose(irq_src[BIT_UPD]) |-> update_event || $past(wr_acc);
  endproperty
  property p_trg_set;
    $rose(irq_src[BIT_TRG]) |-> $past(trig_event) || $past(wr_acc);
  endproperty
  property p_upd_clr;
    $fell(irq_src[BIT_UPD]) |-> $past(wr_acc);
  endproperty
  property p_ch_clr;
    $fell(irq_src[BIT_CH]) |-> $past(wr_acc) || $past(chan_cc_read[0]);
  endproperty
  property p_trg_clr;
    $fell(irq_src[BIT_TRG]) |-> $past(wr_acc);
  endproperty
  a_gen: assert property (p_gen) else $error("no update event");
  a_rep: assert property (p_rep) else $error("no update event");
  a_reinit: assert property (p_reinit) else $error("no update");
  a_irq: assert property (p_irq) else $error("irq low");
  a_slverr: assert property (p_slverr) else $error("no error");
  a_dma_trg: assert property (p_dma_trg) else $error("stray dma");
  a_upd_clr: assert property (p_upd_clr) else $error("lost flag");
  a_ch_clr: assert property (p_ch_clr) else $error("lost flag");
  a_trg_clr: assert property (p_trg_clr) else $error("lost flag");
  a_upd_set: assert property (p_upd_set) else $error("stray flag");
  a_trg_set: assert property (p_trg_set) else $error("stray flag");
endmodule : tef_timer_events_sva

bind tef_timer_events tef_timer_events_sva tef_timer_events_sva_inst (
  .sys_clk(sys_clk),
  .rst_n(rst_n),
  .psel(psel),
  .penable(penable),
  .pwrite(pwrite),
  .paddr(paddr),
  .pslverr(pslverr),
  .update_disable(update_disable),
  .update_source_select(update_source_select),
  .update_generate(update_generate),
  .rep_overflow(rep_overflow),
  .trig_reinit(trig_reinit),
  .trig_event(trig_event),
  .chan_cc_read(chan_cc_read),
  .update_event(update_event),
  .irq(irq),
  .irq_src(irq_src),
  .dma_req(dma_req)
);

// ---- sim/tef_timer_events_test.sv ----
`timescale 1ns/1ps
module tef_timer_events_test;
  import tef_pkg::*;
  typedef struct packed {
    logic [15:0] en;
    logic [1:0] ctl;
    logic [15:0] ev;
    logic [15:0] flg;
    logic irq;
  } tef_row_s;
  // ev: 0 gen, 1 rep, 2 reinit, 3 trig, 4 com, 11:8 match, 15:12 capture
  localparam tef_row_s ROWS [10] = '{
    '{16'h0001, 2'h0, 16'h0001, 16'h0001, 1'h1},
    '{16'h0000, 2'h0, 16'h0002, 16'h0001, 1'h0},
    '{16'h0001, 2'h0, 16'h0004, 16'h0001, 1'h1},
    '{16'h0040, 2'h0, 16'h0008, 16'h0040, 1'h1},
    '{16'h0020, 2'h0, 16'h0010, 16'h0020, 1'h1},
    '{16'h001E, 2'h0, 16'h0F00, 16'h001E, 1'h1},
    '{16'h0000, 2'h0, 16'hF000, 16'h001E, 1'h0},
    '{16'h0001, 2'h1, 16'h0007, 16'h0000, 1'h0},
    '{16'h0001, 2'h2, 16'h0005, 16'h0000, 1'h0},
    '{16'h0001, 2'h2, 16'h0002, 16'h0001, 1'h1}};
  localparam int F1 [4] = '{4, 1, 2, 3};
  localparam int F8 [4] = '{0, 1, 3, 4};
  logic sys_clk;
  logic rst_n = 1'h0;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [ADDR_W-1:0] paddr = 12'h000;
  logic [DATA_W-1:0] pwdata = 32'h0;
  logic [1:0] ctl = 2'h0;
  logic [15:0] ev = 16'h0000;
  logic [3:0] cin = 4'h0;
  logic [3:0] ccr = 4'h0;
  logic [4:0] src = 5'h00;
  logic brk = 1'h0;
  logic [31:0] prdata;
  logic [31:0] q;
  logic pready;
  logic pslverr;
  logic err;
  logic itr_first;
  logic itr_eighth;
  logic irq;
  logic [NUM_DMA-1:0] dma_req;
  logic [7:0] n_dma;
  int n_mismatch = 0;
  int checked = 0;

  tef_timer_events tef_timer_events_inst (
    .sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .update_disable(ctl[0]),
    .update_source_select(ctl[1]), .update_generate(ev[0]),
    .rep_overflow(ev[1]), .trig_reinit(ev[2]), .trig_event(ev[3]),
    .com_event(ev[4]), .break_active(brk), .chan_is_input(cin),
    .chan_match(ev[11:8]), .chan_capture(ev[15:12]),
    .chan_cc_read(ccr), .src_trig(src), .itr_first(itr_first),
    .itr_eighth(itr_eighth), .update_event(), .irq(irq), .irq_src(),
    .dma_req(dma_req));
  tef_req_sink tef_req_sink_inst (.sys_clk(sys_clk), .rst_n(rst_n),
    .dma_req(dma_req), .n_dma(n_dma));

  initial begin
    sys_clk = 1'h0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'h1;
    do @(posedge sys_clk); while (pready !== 1'h1);
    q = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb

  task automatic fire(input logic [15:0] e);
    @(posedge sys_clk);
    ev <= e;
    @(posedge sys_clk);
    ev <= 16'h0000;
  endtask : fire

  task automatic results;
    if (n_mismatch == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : results

  initial begin
    repeat (20000) @(posedge sys_clk);
    n_mismatch++;
    results();
  end

  initial begin
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'h1;
    foreach (ROWS[i]) begin
      apb(1'h1, OFF_REQ_EN, 32'(ROWS[i].en));
      cin <= ROWS[i].ev[15:12];
      ctl <= ROWS[i].ctl;
      fire(ROWS[i].ev);
      apb(1'h0, OFF_FLAGS, 32'h0);
      chk(q, 32'(ROWS[i].flg));
      chk(32'(irq), 32'(ROWS[i].irq));
      apb(1'h1, OFF_FLAGS, 32'h0);
    end
    ctl <= 2'h0;
    cin <= 4'h1;
    // Channel 1 enabled so the read-clear path drops a live request
    apb(1'h1, OFF_REQ_EN, 32'h0043);
    fire(16'h1009);
    apb(1'h1, OFF_FLAGS, 32'h0000FFFE);
    apb(1'h0, OFF_FLAGS, 32'h0);
    chk(q, 32'h42);
    @(posedge sys_clk);
    ccr <= 4'h1;
    @(posedge sys_clk);
    ccr <= 4'h0;
    apb(1'h0, OFF_FLAGS, 32'h0);
    chk(q, 32'h40);
    chk(32'(irq), 32'h1);
    apb(1'h1, OFF_REQ_EN, 32'hFFFF);
    apb(1'h0, OFF_REQ_EN, 32'h0);
    chk(q, 32'h7FFF);
    chk(32'(err), 32'h0);
    rst_n <= 1'h0;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'h1;
    apb(1'h0, OFF_REQ_EN, 32'h0);
    chk(q, 32'h0);
    apb(1'h0, OFF_FLAGS, 32'h0);
    chk(q, 32'h0);
    // Only trigger and channel 1 transfers may be requested
    apb(1'h1, OFF_REQ_EN, 32'h4200);
    cin <= 4'h0;
    fire(16'h0109);
    repeat (2) @(negedge sys_clk);
    chk(32'(n_dma), 32'h2);
    chk(32'(irq), 32'h0);
    apb(1'h0, 12'h004, 32'h0);
    chk(q, 32'h0);
    chk(32'(err), 32'h1);
    apb(1'h1, OFF_FLAGS, 32'h0);
    apb(1'h1, OFF_REQ_EN, 32'h0080);
    brk <= 1'h1;
    @(posedge sys_clk);
    brk <= 1'h0;
    apb(1'h0, OFF_FLAGS, 32'h0);
    chk(q, 32'h80);
    chk(32'(irq), 32'h1);
    for (int c = 0; c < 4; c++) begin
      apb(1'h1, OFF_TRIG_SEL, 32'(c * 17));
      src <= 5'h01 << F1[c];
      @(negedge sys_clk);
      chk(32'(itr_first), 32'h1);
      @(posedge sys_clk);
      src <= ~(5'h01 << F1[c]);
      @(negedge sys_clk);
      chk(32'(itr_first), 32'h0);
      @(posedge sys_clk);
      src <= 5'h01 << F8[c];
      @(negedge sys_clk);
      chk(32'(itr_eighth), 32'h1);
      @(posedge sys_clk);
      src <= ~(5'h01 << F8[c]);
      @(negedge sys_clk);
      chk(32'(itr_eighth), 32'h0);
    end
    // Codes 1xx select no internal trigger at all
    apb(1'h1, OFF_TRIG_SEL, 32'h44);
    src <= 5'h1F;
    @(negedge sys_clk);
    chk(32'(itr_first), 32'h0);
    chk(32'(itr_eighth), 32'h0);
    results();
  end
endmodule : tef_timer_events_test
